//--- design/serial_port_baud_gen_status.sv
/*
 Baud generator and status register of the synchronous serial unit.
 Assumes an APB master on core_clk_i and event pulses from the serial engine
 on the same clock; serial lines leave as plain level outputs.
*/
// What this block does
// - The baud counter reloads from the software reload register in master clock generation.
// - A write to the shift buffer starts the baud counter while the port is enabled and idle, without any other command.
// - After the operation completes the counter stops and the serial clock keeps its level.
// - The counter is reloaded twice per serial clock period, once per half period.
// - Serial clock frequency is oscillator divided by four times reload plus one.
// - Unimplemented locations and bits read as zero.
// - Status is eight bits, resets to zero, top two bits writable, rest read only.
// - In SPI master the sample bit picks end-of-output or middle sampling.
// - In I2C the sample bit set disables slew control, clear enables it.
// - In SPI the edge bit picks the clock transition that launches data.
// - Stop-seen and start-seen are cleared while the serial port is disabled.
// - Buffer full reads one once a received byte sits in the shift buffer.
`timescale 1ns/10ps
module serial_port_baud_gen_status (
	input wire logic core_clk_i, // System clock, 40 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [11:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic rx_done_i, // Engine pulse: byte received
	input wire logic [7:0] rx_byte_i, // Engine received byte
	input wire logic start_det_i, // Engine pulse: start seen
	input wire logic stop_det_i, // Engine pulse: stop seen
	input wire logic data_byte_i, // Engine level: last byte was data
	input wire logic rw_info_i, // Engine level: read/write info
	input wire logic addr_update_i, // Engine pulse: address needs update
	output logic serial_clk_o, // Generated serial clock
	output logic baud_active_o, // Baud counter running
	output logic sample_at_end_o, // SPI sample at end of output time
	output logic launch_on_fall_o, // SPI launch on active-to-idle edge
	output logic slew_ctrl_en_o, // I2C slew control enabled
	output logic smbus_levels_o // I2C SMBus input thresholds
);
	sp_baud_pkg::status_ctrl_t ctrl_bits;
	sp_baud_pkg::status_ro_t ro_bits;
	sp_baud_pkg::baud_state_t state;
	logic [7:0] reload;
	logic [7:0] count;
	logic [7:0] shift_buf;
	logic prescale;
	logic [3:0] half_left;
	logic port_en;
	logic mode_i2c;
	logic access;
	logic wr;
	logic tick;
	logic rollover;
	logic [7:0] status_byte;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
		return a == base;
	endfunction

	assign access = psel_i & penable_i;
	assign wr = access & pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign status_byte = {ctrl_bits, ro_bits};

	// Single-cycle access phase keeps the bus path simple
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			if (hit(paddr_i, sp_baud_pkg::ADDR_STATUS)) begin
				prdata_o <= {24'h000000, status_byte};
			end else if (hit(paddr_i, sp_baud_pkg::ADDR_RELOAD)) begin
				prdata_o <= {24'h000000, reload};
			end else if (hit(paddr_i, sp_baud_pkg::ADDR_SHIFT)) begin
				prdata_o <= {24'h000000, shift_buf};
			end else if (hit(paddr_i, sp_baud_pkg::ADDR_CTRL)) begin
				prdata_o <= {30'h0000_0000, mode_i2c, port_en};
			end else if (hit(paddr_i, sp_baud_pkg::ADDR_COUNT)) begin
				prdata_o <= {24'h000000, count};
			end else begin
				prdata_o <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_bits <= '0;
		end else if (wr && hit(paddr_i, sp_baud_pkg::ADDR_STATUS)) begin
			ctrl_bits.sample <= pwdata_i[sp_baud_pkg::BIT_SAMPLE];
			ctrl_bits.edge_sel <= pwdata_i[sp_baud_pkg::BIT_EDGE];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reload <= sp_baud_pkg::RELOAD_RESET;
			port_en <= 1'b0;
			mode_i2c <= 1'b0;
		end else if (wr) begin
			if (hit(paddr_i, sp_baud_pkg::ADDR_RELOAD)) begin
				reload <= pwdata_i[7:0];
			end
			if (hit(paddr_i, sp_baud_pkg::ADDR_CTRL)) begin
				port_en <= pwdata_i[sp_baud_pkg::CTRL_ENABLE];
				mode_i2c <= pwdata_i[sp_baud_pkg::CTRL_I2C];
			end
		end
	end

	// Read-only status; the disable clear wins over a new event, which sets its flag only while enabled
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ro_bits <= '0;
		end else begin
			ro_bits.data_not_addr <= data_byte_i;
			ro_bits.read_write <= rw_info_i;
			ro_bits.update <= addr_update_i | (ro_bits.update & ~(wr &&
				hit(paddr_i, sp_baud_pkg::ADDR_RELOAD)));
			if (!port_en) begin
				ro_bits.stop_seen <= 1'b0;
				ro_bits.start_seen <= 1'b0;
			end else if (start_det_i) begin
				ro_bits.start_seen <= 1'b1;
				ro_bits.stop_seen <= 1'b0;
			end else if (stop_det_i) begin
				ro_bits.stop_seen <= 1'b1;
				ro_bits.start_seen <= 1'b0;
			end
			if (rx_done_i) begin
				ro_bits.full <= 1'b1;
			end else if (access && !pwrite_i && hit(paddr_i, sp_baud_pkg::ADDR_SHIFT)) begin
				ro_bits.full <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_buf <= sp_baud_pkg::ZERO8;
		end else if (rx_done_i) begin
			shift_buf <= rx_byte_i;
		end else if (wr && hit(paddr_i, sp_baud_pkg::ADDR_SHIFT)) begin
			shift_buf <= pwdata_i[7:0];
		end
	end

	// Step every second clock so two rollovers span four times reload plus one
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale <= sp_baud_pkg::PRESCALE_ZERO;
		end else begin
			prescale <= ~prescale;
		end
	end
	assign tick = prescale == sp_baud_pkg::PRESCALE_LAST;
	assign rollover = tick && count == sp_baud_pkg::ZERO8;

	// Eight serial clock periods, two half periods each, per shift buffer write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= sp_baud_pkg::ST_IDLE;
			count <= sp_baud_pkg::ZERO8;
			half_left <= 4'h0;
			serial_clk_o <= 1'b0;
		end else begin
			case (state)
				sp_baud_pkg::ST_IDLE: begin
					if (port_en && wr && hit(paddr_i, sp_baud_pkg::ADDR_SHIFT)) begin
						count <= reload;
						half_left <= sp_baud_pkg::BITS_PER_BYTE;
						state <= sp_baud_pkg::ST_LOW;
					end
				end
				sp_baud_pkg::ST_LOW: begin
					if (tick) begin
						count <= count - sp_baud_pkg::ONE8;
					end
					if (rollover) begin
						count <= reload;
						serial_clk_o <= ~serial_clk_o;
						state <= sp_baud_pkg::ST_HIGH;
					end
				end
				sp_baud_pkg::ST_HIGH: begin
					if (tick) begin
						count <= count - sp_baud_pkg::ONE8;
					end
					if (rollover) begin
						count <= reload;
						serial_clk_o <= ~serial_clk_o;
						half_left <= half_left - 4'h1;
						state <= (half_left == 4'h1) ? sp_baud_pkg::ST_IDLE :
							sp_baud_pkg::ST_LOW;
					end
				end
				default: state <= sp_baud_pkg::ST_IDLE;
			endcase
			if (!port_en) begin
				state <= sp_baud_pkg::ST_IDLE;
			end
		end
	end

	assign baud_active_o = state != sp_baud_pkg::ST_IDLE;
	assign sample_at_end_o = ~mode_i2c & ctrl_bits.sample;
	assign launch_on_fall_o = ~mode_i2c & ctrl_bits.edge_sel;
	assign slew_ctrl_en_o = mode_i2c & ~ctrl_bits.sample;
	assign smbus_levels_o = mode_i2c & ctrl_bits.edge_sel;

	// Checks
	logic [9:0] idle_run;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_run <= 10'h000;
		end else if (baud_active_o && !rollover) begin
			idle_run <= idle_run + 10'h001;
		end else begin
			idle_run <= 10'h000;
		end
	end

	property p_reload_on_roll;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rollover && baud_active_o |=> count == $past(reload);
	endproperty
	a_reload_on_roll: assert property (p_reload_on_roll) else $error("no reload at rollover");

	property p_start_on_write;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!baud_active_o && port_en && wr && paddr_i == sp_baud_pkg::ADDR_SHIFT |=> baud_active_o;
	endproperty
	a_start_on_write: assert property (p_start_on_write) else $error("write did not start");

	property p_hold_idle;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!baud_active_o ##1 !baud_active_o |-> $stable(serial_clk_o);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("clock moved while idle");

	property p_toggle_on_roll;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		baud_active_o && rollover |=> serial_clk_o != $past(serial_clk_o);
	endproperty
	a_toggle_on_roll: assert property (p_toggle_on_roll) else $error("no toggle");

	property p_half_length;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		idle_run <= {1'b0, reload, 1'b1};
	endproperty
	a_half_length: assert property (p_half_length) else $error("half period too long");

	property p_unmapped_zero;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		psel_i && !penable_i && !pwrite_i && paddr_i[11:5] != 7'h00 |=> prdata_o == 32'h0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

	property p_ro_bits;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		prdata_o[31:8] == 24'h000000;
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("upper bits set");

	property p_disable_clears;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!port_en |=> !ro_bits.start_seen && !ro_bits.stop_seen;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("flags kept");

	property p_full_set;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rx_done_i |=> ro_bits.full && shift_buf == $past(rx_byte_i);
	endproperty
	a_full_set: assert property (p_full_set) else $error("full not set");

	property p_mode_pins;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		mode_i2c |-> !sample_at_end_o && !launch_on_fall_o && slew_ctrl_en_o == !ctrl_bits.sample;
	endproperty
	a_mode_pins: assert property (p_mode_pins) else $error("mode pins wrong");

	property p_sample_write;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		wr && paddr_i == sp_baud_pkg::ADDR_STATUS && !mode_i2c |=>
			sample_at_end_o == $past(pwdata_i[sp_baud_pkg::BIT_SAMPLE]);
	endproperty
	a_sample_write: assert property (p_sample_write) else $error("sample pin wrong");

	property p_edge_write;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		wr && paddr_i == sp_baud_pkg::ADDR_STATUS && !mode_i2c |=>
			launch_on_fall_o == $past(pwdata_i[sp_baud_pkg::BIT_EDGE]);
	endproperty
	a_edge_write: assert property (p_edge_write) else $error("launch pin wrong");

	property p_smbus_write;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		wr && paddr_i == sp_baud_pkg::ADDR_STATUS && mode_i2c |=>
			smbus_levels_o == $past(pwdata_i[sp_baud_pkg::BIT_EDGE]);
	endproperty
	a_smbus_write: assert property (p_smbus_write) else $error("threshold pin wrong");

	property p_stop_after_byte;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rollover && state == sp_baud_pkg::ST_HIGH && half_left == 4'h1 |=> !baud_active_o;
	endproperty
	a_stop_after_byte: assert property (p_stop_after_byte) else $error("no stop at end");

	property p_idle_count;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!baud_active_o && !(port_en && wr && paddr_i == sp_baud_pkg::ADDR_SHIFT) |=>
			$stable(count);
	endproperty
	a_idle_count: assert property (p_idle_count) else $error("count moved while idle");

	property p_count_step;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		baud_active_o && tick && !rollover |=> count == $past(count) - sp_baud_pkg::ONE8;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step");

	property p_full_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		access && !pwrite_i && paddr_i == sp_baud_pkg::ADDR_SHIFT && !rx_done_i |=>
			!ro_bits.full;
	endproperty
	a_full_clear: assert property (p_full_clear) else $error("full kept after read");

	property p_enable_stops;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!port_en |=> !baud_active_o;
	endproperty
	a_enable_stops: assert property (p_enable_stops) else $error("ran while disabled");

	c_start: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(baud_active_o));
	c_finish: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(baud_active_o));
	c_rx: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) rx_done_i);
	c_toggle: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		baud_active_o && rollover);
	c_i2c_run: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(baud_active_o) && mode_i2c);
endmodule

//--- design/sp_baud_pkg.sv
/*
 Package for the serial port baud generator and status block.
 Holds register offsets, status bit positions, reset values, timing constants
 and the carrier structs shared by the design.
*/
package sp_baud_pkg;
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_RELOAD = 12'h004;
	localparam logic [11:0] ADDR_SHIFT = 12'h008;
	localparam logic [11:0] ADDR_CTRL = 12'h00c;
	localparam logic [11:0] ADDR_COUNT = 12'h010;

	localparam int BIT_SAMPLE = 7;
	localparam int BIT_EDGE = 6;
	localparam int BIT_DATA_ADDR = 5;
	localparam int BIT_STOP = 4;
	localparam int BIT_START = 3;
	localparam int BIT_RW = 2;
	localparam int BIT_UPDATE = 1;
	localparam int BIT_FULL = 0;

	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_I2C = 1;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic PRESCALE_LAST = 1'b1;
	localparam logic PRESCALE_ZERO = 1'b0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] I2C_MIN_RELOAD = 8'h03;

	typedef struct packed {
		logic sample;
		logic edge_sel;
	} status_ctrl_t;

	typedef struct packed {
		logic data_not_addr;
		logic stop_seen;
		logic start_seen;
		logic read_write;
		logic update;
		logic full;
	} status_ro_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b100
	} baud_state_t;
endpackage

//--- testbench/serial_slave_model.sv
/*
 Far-side model: serial engine and bus slave events fed to the baud block.
 Assumes core_clk_i is the block's clock; tasks are called just after an edge.
*/
`timescale 1ns/10ps
module serial_slave_model (
	input wire logic core_clk_i, // Core clock
	input wire logic serial_clk_i, // Serial clock from the block
	output logic rx_done_o, // Byte received pulse
	output logic [7:0] rx_byte_o, // Received byte
	output logic start_det_o, // Start seen pulse
	output logic stop_det_o, // Stop seen pulse
	output logic data_byte_o, // Last byte was data
	output logic rw_info_o, // Read or write info
	output logic addr_update_o, // Address update pulse
	output logic [15:0] half_len_o, // Last serial half period in core cycles
	output logic [7:0] edges_o // Serial clock edges seen
);
	logic [15:0] run = 16'h0000;
	logic last = 1'b0;
	initial begin
		{rx_done_o, start_det_o, stop_det_o, data_byte_o, rw_info_o, addr_update_o} = 6'h00;
		rx_byte_o = 8'h00;
		half_len_o = 16'h0000;
		edges_o = 8'h00;
	end
	// Pulses last one cycle; data and read/write info are levels and stay
	task pulse(input logic [5:0] ev, input logic [7:0] b);
		{rx_done_o, start_det_o, stop_det_o, data_byte_o, rw_info_o, addr_update_o} <= ev;
		rx_byte_o <= b;
		@(posedge core_clk_i);
		{rx_done_o, start_det_o, stop_det_o, addr_update_o} <= 4'h0;
		@(posedge core_clk_i);
	endtask
	always @(posedge core_clk_i) begin
		run <= run + 16'h0001;
		last <= serial_clk_i;
		if (serial_clk_i !== last) begin
			half_len_o <= run + 16'h0001;
			run <= 16'h0000;
			edges_o <= edges_o + 8'h01;
		end
	end
endmodule

//--- testbench/tb_serial_port_baud_gen_status.sv
/*
 Self-checking bench for the baud generator and status block.
 Assumes a one-cycle APB slave and the far-side model for engine events.
*/
`timescale 1ns/10ps
module tb_serial_port_baud_gen_status;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000, prdata_o;
	logic pready_o, pslverr_o, rx_done_i, start_det_i, stop_det_i, data_byte_i, rw_info_i;
	logic addr_update_i, serial_clk_o, baud_active_o, sample_at_end_o, launch_on_fall_o;
	logic slew_ctrl_en_o, smbus_levels_o;
	logic [7:0] rx_byte_i, edges, e0, r, b;
	logic [15:0] half_len;
	logic [31:0] exp_q[$];
	int n_errors = 0, checks = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	serial_port_baud_gen_status serial_port_baud_gen_status_i (.core_clk_i, .rst_n_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_done_i,
		.rx_byte_i, .start_det_i, .stop_det_i, .data_byte_i, .rw_info_i, .addr_update_i,
		.serial_clk_o, .baud_active_o, .sample_at_end_o, .launch_on_fall_o, .slew_ctrl_en_o,
		.smbus_levels_o);
	serial_slave_model serial_slave_model_i (.core_clk_i, .serial_clk_i(serial_clk_o),
		.rx_done_o(rx_done_i), .rx_byte_o(rx_byte_i), .start_det_o(start_det_i),
		.stop_det_o(stop_det_i), .data_byte_o(data_byte_i), .rw_info_o(rw_info_i),
		.addr_update_o(addr_update_i), .half_len_o(half_len), .edges_o(edges));
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Trailing edge wait keeps two transfers from driving psel in one time step
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		@(posedge core_clk_i);
		while (pready_o !== 1'b1) @(posedge core_clk_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		apb(a, 1'b0, 32'h00000000);
	endtask
	always @(posedge core_clk_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
			cmp(prdata_o, exp_q.pop_front());
		end
	end
	task run_baud(input logic [7:0] rl);
		apb(sp_baud_pkg::ADDR_RELOAD, 1'b1, {24'h000000, rl});
		e0 = edges;
		apb(sp_baud_pkg::ADDR_SHIFT, 1'b1, $urandom);
		cmp(baud_active_o, 1'b1);
		for (int i = 0; i < 3000 && edges !== e0 + 8'h02; i++) @(posedge core_clk_i);
		cmp(edges, 8'(e0 + 8'h02));
		#1 cmp(half_len, 16'(2 * (rl + 1)));
		for (int i = 0; i < 3000 && baud_active_o !== 1'b0; i++) @(posedge core_clk_i);
		repeat (3) @(posedge core_clk_i);
		cmp(8'(edges - e0), 8'h10);
		b = {7'h00, serial_clk_o};
		repeat (40) @(posedge core_clk_i);
		cmp(serial_clk_o, b[0]);
		cmp(baud_active_o, 1'b0);
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#500000;
		n_errors++;
		close_out;
	end
	initial begin
		void'($urandom(93371));
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		rd(sp_baud_pkg::ADDR_STATUS, 32'h00000000);
		rd(sp_baud_pkg::ADDR_RELOAD, 32'h00000000);
		apb(12'h014, 1'b1, $urandom);
		rd(12'h014, 32'h00000000);
		$display("test reset and map done");
		for (int i = 0; i < 8; i++) begin
			apb(sp_baud_pkg::ADDR_CTRL, 1'b1, {30'h0, i[2], 1'b1});
			apb(sp_baud_pkg::ADDR_STATUS, 1'b1, {24'($urandom), i[1:0], 6'h3f});
			rd(sp_baud_pkg::ADDR_STATUS, {24'h0, i[1:0], 6'h00});
			if (i < 4) begin
				cmp(sample_at_end_o, i[1]);
				cmp(launch_on_fall_o, i[0]);
				cmp(slew_ctrl_en_o | smbus_levels_o, 1'b0);
			end else begin
				cmp(slew_ctrl_en_o, !i[1]);
				cmp(smbus_levels_o, i[0]);
				cmp(sample_at_end_o | launch_on_fall_o, 1'b0);
			end
		end
		apb(sp_baud_pkg::ADDR_STATUS, 1'b1, 32'h00000000);
		$display("test mode bits done");
		r = 8'($urandom);
		serial_slave_model_i.pulse(6'b110110, r);
		rd(sp_baud_pkg::ADDR_STATUS, 32'h0000002d);
		rd(sp_baud_pkg::ADDR_SHIFT, {24'h0, r});
		rd(sp_baud_pkg::ADDR_STATUS, 32'h0000002c);
		serial_slave_model_i.pulse(6'b001111, 8'h00);
		rd(sp_baud_pkg::ADDR_STATUS, 32'h00000036);
		apb(sp_baud_pkg::ADDR_CTRL, 1'b1, 32'h00000002);
		rd(sp_baud_pkg::ADDR_STATUS, 32'h00000026);
		$display("test status events done");
		apb(sp_baud_pkg::ADDR_CTRL, 1'b1, 32'h00000003);
		run_baud(sp_baud_pkg::I2C_MIN_RELOAD);
		run_baud(8'h03 + 8'($urandom % 20));
		$display("test baud generator done");
		close_out;
	end
endmodule
